// ===== dcm_pkg.sv
package dcm_pkg;

  // ****************************************************************
  // Sizes
  // ****************************************************************
  localparam int DCM_PERIOD_W = 12;   // Width of reference period count
  localparam int DCM_TAPS     = 64;   // Delay line length in taps
  localparam int DCM_TAP_W    = 6;    // Width of tap select
  localparam int DCM_NUM_OUT  = 9;    // Output clocks
  localparam int DCM_NUM_GLB  = 4;    // Outputs that may reach global buffers
  localparam int DCM_SYNC_N   = 5;    // Pins passed through synchronisers

  // ****************************************************************
  // Counts and reset values
  // ****************************************************************
  localparam logic [4:0]  DCM_LOCK_EDGES  = 5'h10;   // Aligned edges before lock
  localparam logic [11:0] DCM_STOP_CYCLES = 12'hFA0; // Idle cycles meaning stopped
  localparam logic [4:0]  DCM_DEFAULT_M   = 5'h04;   // Multiplier when unset
  localparam logic [4:0]  DCM_DEFAULT_D   = 5'h01;   // Divider when unset
  localparam logic [5:0]  DCM_DIV_X2_MIN  = 6'h03;   // Divide by 1.5, doubled
  localparam logic [5:0]  DCM_DIV_X2_MAX  = 6'h20;   // Divide by 16, doubled
  localparam logic [5:0]  DCM_DIV_X2_INT  = 6'h10;   // From here only integers
  localparam logic signed [9:0] DCM_PHASE_MAX = 10'sh0FF; // Phase setting limit
  localparam int DCM_PHASE_FRAC = 8;  // Phase unit is period over 256

  // ****************************************************************
  // Field positions
  // ****************************************************************
  localparam int DCM_ST_OVERFLOW = 0;
  localparam int DCM_ST_REF_STOP = 1;
  localparam int DCM_ST_FX_STOP  = 2;
  localparam int DCM_O_P0    = 0;
  localparam int DCM_O_P90   = 1;
  localparam int DCM_O_P180  = 2;
  localparam int DCM_O_P270  = 3;
  localparam int DCM_O_2X    = 4;
  localparam int DCM_O_2X180 = 5;
  localparam int DCM_O_DV    = 6;
  localparam int DCM_O_FX    = 7;
  localparam int DCM_O_FX180 = 8;
  localparam int DCM_PIN_REF = 0;
  localparam int DCM_PIN_FB  = 1;
  localparam int DCM_PIN_PSC = 2;
  localparam int DCM_PIN_REQ = 3;
  localparam int DCM_PIN_DIR = 4;

  // ****************************************************************
  // Enumerations
  // ****************************************************************
  typedef enum logic [1:0] {DCM_PS_NONE, DCM_PS_FIXED, DCM_PS_VARIABLE} dcm_ps_mode_e;
  typedef enum logic [1:0] {DCM_SH_IDLE, DCM_SH_WAIT, DCM_SH_PULSE, DCM_SH_END} dcm_shift_e;

endpackage

// ===== dcm_edge_sync.sv
module dcm_edge_sync
  import dcm_pkg::*;
(
  input  wire logic clock_in,
  input  wire logic rst_in,
  input  wire logic async_in,
  output logic      level_out,
  output logic      rise_out
);

  typedef struct packed {
    logic stage1;
    logic stage2;
    logic prev;
  } dcm_sync_s;

  dcm_sync_s st_reg;
  dcm_sync_s st_next;

  // Two flops, then one more for edge detection
  always_comb
  begin
    st_next        = st_reg;
    st_next.stage1 = async_in;
    st_next.stage2 = st_reg.stage1;
    st_next.prev   = st_reg.stage2;
  end

  always_ff @(posedge clock_in or posedge rst_in)
  begin
    if (rst_in)
      st_reg <= '0;
    else
      st_reg <= st_next;
  end

  assign level_out = st_reg.stage2;
  assign rise_out  = st_reg.stage2 & ~st_reg.prev;

endmodule // dcm_edge_sync

// ===== dcm_delay_line.sv
module dcm_delay_line
  import dcm_pkg::*;
#(
  parameter int TAPS  = DCM_TAPS,
  parameter int TAP_W = DCM_TAP_W
)
(
  input  wire logic             clock_in,
  input  wire logic             rst_in,
  input  wire logic             data_in,
  input  wire logic [TAP_W-1:0] tap_in,
  output logic                  data_out
);

  typedef struct packed {
    logic [TAPS-1:0] line;
    logic            out;
  } dcm_delay_s;

  dcm_delay_s st_reg;
  dcm_delay_s st_next;

  // Shift samples along the line and pick the selected tap
  always_comb
  begin
    st_next      = st_reg;
    st_next.line = {st_reg.line[TAPS-2:0], data_in};
    st_next.out  = st_reg.line[tap_in];
  end

  always_ff @(posedge clock_in or posedge rst_in)
  begin
    if (rst_in)
      st_reg <= '0;
    else
      st_reg <= st_next;
  end

  assign data_out = st_reg.out;

endmodule // dcm_delay_line

// ===== dcm_clock_manager.sv
// Overview of operation
// - Reset clears delay line, lock, phase state
// - Lock flag high only when all enabled loops locked
// - Status bits: overflow, reference stopped, synth stopped
// - Configuration completion can wait for lock
// - Delay line adjusted so edges match reference
// - Phase and doubled outputs aligned to phase zero output
// - Doubled outputs run at twice reference frequency
// - Divider 1.5 to 7.5 halves, 8 to 16
// - Synth runs at M over D, default 4/1
// - Inverted outputs lag by half a period
// - Synthesis outputs 50/50 except fractional divide high-frequency
// - Four phase outputs spaced a quarter period
// - High-frequency mode drops 90, 270, doubled outputs
// - Fine phase shift moves the four phase and two doubled outputs
// - Phase offset equals setting/256 times period
// - Phase setting limited to plus/minus 255
// - Shift clock edge with request steps phase
// - Variable mode centres zero skew in delay line
// - Fixed mode phase constant, whole line usable
// - At most four outputs reach global buffers
// - Frequency mode follows configuration input every cycle
module dcm_clock_manager
  import dcm_pkg::*;
#(
  parameter int PW    = DCM_PERIOD_W,
  parameter int TAPS  = DCM_TAPS,
  parameter int TAP_W = DCM_TAP_W
)
(
  input  wire logic              clock_in,
  input  wire logic              rst_in,
  input  wire logic              ref_clock_in,
  input  wire logic              feedback_clock_in,
  input  wire logic              shift_clock_in,
  input  wire logic              shift_request_in,
  input  wire logic              shift_direction_in,
  input  wire logic              feedback_used_in,
  input  wire logic              high_freq_mode_in,
  input  wire logic              lock_wait_in,
  input  wire logic [1:0]        phase_mode_in,
  input  wire logic signed [8:0] phase_offset_setting_in,
  input  wire logic [5:0]        divide_x2_in,
  input  wire logic [4:0]        synth_mult_in,
  input  wire logic [4:0]        synth_div_in,
  input  wire logic [8:0]        global_enable_in,
  output logic                   out_phase_0_out,
  output logic                   out_phase_90_out,
  output logic                   out_phase_180_out,
  output logic                   out_phase_270_out,
  output logic                   doubled_clock_out,
  output logic                   doubled_clock_inverted_out,
  output logic                   divided_clock_out,
  output logic                   synth_clock_out,
  output logic                   synth_clock_inverted_out,
  output logic [3:0]             global_clock_out,
  output logic                   global_overuse_out,
  output logic                   lock_flag_out,
  output logic [7:0]             status_out,
  output logic                   shift_complete_out,
  output logic                   config_done_out
);

  localparam int EW = PW + 4;   // Signed width for edge offsets

  typedef struct packed {
    logic [PW-1:0]          ref_cnt;
    logic [PW-1:0]          period;
    logic                   period_ok;
    logic [PW-1:0]          gen_cnt;
    logic                   dly_prev;
    logic [TAP_W-1:0]       tap;
    logic [4:0]             lock_cnt;
    logic                   locked;
    logic                   cfg_seen;
    logic signed [9:0]      phase;
    dcm_shift_e             sh_state;
    logic                   overflow;
    logic                   shift_done;
    logic [11:0]            ref_idle;
    logic [11:0]            fx_idle;
    logic                   ref_stop;
    logic                   fx_stop;
    logic [PW+4:0]          dv_cnt;
    logic [PW+5:0]          fx_acc;
    logic [DCM_NUM_OUT-1:0] clk;
    logic [3:0]             glb;
    logic                   glb_over;
  } dcm_state_s;

  dcm_state_s st_reg;
  dcm_state_s st_next;

  // ****************************************************************
  // Pin synchronisers and delay line
  // ****************************************************************
  logic [DCM_SYNC_N-1:0] pin_async;
  logic [DCM_SYNC_N-1:0] pin_lvl;
  logic [DCM_SYNC_N-1:0] pin_rise;
  logic                  dly_ref;

  assign pin_async = {shift_direction_in, shift_request_in, shift_clock_in,
                      feedback_clock_in, ref_clock_in};

  // One synchroniser per outside pin
  for (genvar i = 0; i < DCM_SYNC_N; i++)
  begin : g_sync
    dcm_edge_sync u_sync (
      .clock_in  (clock_in),
      .rst_in    (rst_in),
      .async_in  (pin_async[i]),
      .level_out (pin_lvl[i]),
      .rise_out  (pin_rise[i])
    );
  end

  // Tap select delays the reference that the phase and doubled outputs derive from
  dcm_delay_line #(.TAPS(TAPS), .TAP_W(TAP_W)) u_line (
    .clock_in (clock_in),
    .rst_in   (rst_in),
    .data_in  (pin_lvl[DCM_PIN_REF]),
    .tap_in   (st_reg.tap),
    .data_out (dly_ref)
  );

  // ****************************************************************
  // Derived quantities
  // ****************************************************************
  logic [4:0]             m_eff;
  logic [4:0]             d_eff;
  logic [5:0]             div_eff;
  logic [PW-1:0]          half;
  logic [PW-1:0]          quarter;
  logic [PW-1:0]          ref_inc;
  logic signed [PW+10:0]  phase_prod;
  logic signed [PW+10:0]  step_prod;
  logic signed [EW-1:0]   target;
  logic signed [EW-1:0]   step_cyc;
  logic signed [EW-1:0]   offset;
  logic signed [EW-1:0]   err;
  logic signed [9:0]      step_phase;
  logic signed [9:0]      cfg_phase;
  logic                   step_ok;
  logic                   aligned;
  logic                   dly_rise;
  logic                   run;
  logic [PW+4:0]          fx_span;
  logic [PW+5:0]          dv_prod;
  logic [PW+4:0]          dv_len;
  logic [PW+4:0]          dv_hi;
  logic [PW+5:0]          fx_sum;

  // Unset synth factors fall back to 4 over 1
  assign m_eff = (synth_mult_in == 5'h00) ? DCM_DEFAULT_M : synth_mult_in;
  assign d_eff = (synth_div_in == 5'h00) ? DCM_DEFAULT_D : synth_div_in;

  // Divider clamp: halves up to 7.5, whole numbers beyond
  always_comb
  begin
    if (divide_x2_in < DCM_DIV_X2_MIN)
      div_eff = DCM_DIV_X2_MIN;
    else if (divide_x2_in > DCM_DIV_X2_MAX)
      div_eff = DCM_DIV_X2_MAX;
    else if (divide_x2_in > DCM_DIV_X2_INT)
      div_eff = {divide_x2_in[5:1], 1'b0};
    else
      div_eff = divide_x2_in;
  end

  assign half     = st_reg.period >> 1;
  assign quarter  = st_reg.period >> 2;
  assign ref_inc  = st_reg.ref_cnt + {{(PW-1){1'b0}}, 1'b1};
  assign dly_rise = dly_ref & ~st_reg.dly_prev;
  assign run      = st_reg.period_ok & ~st_reg.ref_stop;

  // Offset in cycles is setting times period over 256
  assign phase_prod = $signed(st_reg.phase) * $signed({1'b0, st_reg.period});
  assign step_prod  = $signed(step_phase) * $signed({1'b0, st_reg.period});
  assign target     = EW'(phase_prod >>> DCM_PHASE_FRAC);
  assign step_cyc   = EW'(step_prod >>> DCM_PHASE_FRAC);

  // One step up or down, refused past 255 or half the line
  assign step_phase = pin_lvl[DCM_PIN_DIR] ? st_reg.phase + 10'sh001
                                           : st_reg.phase - 10'sh001;
  assign step_ok    = (step_phase <= DCM_PHASE_MAX) && (step_phase >= -DCM_PHASE_MAX)
                      && (step_cyc <= EW'(TAPS / 2))
                      && (step_cyc >= -EW'(TAPS / 2));

  // Configured offset, -256 pulled in to -255
  assign cfg_phase = (phase_offset_setting_in < -9'sh0FF) ? -DCM_PHASE_MAX
                     : 10'(phase_offset_setting_in);

  // Feedback position relative to the reference edge, wrapped to +-half
  assign offset  = ({4'h0, st_reg.ref_cnt} > {4'h0, half})
                   ? $signed({4'h0, st_reg.ref_cnt}) - $signed({4'h0, st_reg.period})
                   : $signed({4'h0, st_reg.ref_cnt});
  assign err     = offset - target;
  assign aligned = (err <= EW'(1)) && (err >= -EW'(1));

  // Synth span and divider lengths in clock cycles
  assign fx_span = {5'h00, st_reg.period} * {{PW{1'b0}}, d_eff};
  assign dv_prod = {6'h00, st_reg.period} * {{PW{1'b0}}, div_eff};
  assign dv_len  = dv_prod[PW+5:1];
  assign dv_hi   = (high_freq_mode_in && div_eff[0])
                   ? (dv_len >> 1) + {5'h00, quarter}
                   : dv_len >> 1;
  assign fx_sum  = st_reg.fx_acc + {{PW{1'b0}}, m_eff, 1'b0};

  // ****************************************************************
  // Next state
  // ****************************************************************
  always_comb
  begin
    int unsigned used;
    used     = 0;
    st_next  = st_reg;
    st_next.dly_prev = dly_ref;

    // Reference period measurement and idle watch
    if (pin_rise[DCM_PIN_REF])
    begin
      st_next.ref_cnt   = '0;
      st_next.period    = ref_inc;
      st_next.period_ok = (ref_inc == st_reg.period);
      st_next.ref_idle  = '0;
    end
    else
    begin
      if (st_reg.ref_cnt != '1)
        st_next.ref_cnt = ref_inc;
      if (st_reg.ref_idle != DCM_STOP_CYCLES)
        st_next.ref_idle = st_reg.ref_idle + 12'h001;
    end
    st_next.ref_stop = (st_next.ref_idle == DCM_STOP_CYCLES);
    if (st_next.ref_stop)
      st_next.period_ok = 1'b0;

    // Output phase counter restarts on the delayed reference
    if (dly_rise)
      st_next.gen_cnt = '0;
    else if (st_reg.gen_cnt != '1)
      st_next.gen_cnt = st_reg.gen_cnt + {{(PW-1){1'b0}}, 1'b1};

    // Capture configuration once after reset release
    if (!st_reg.cfg_seen)
    begin
      st_next.cfg_seen = 1'b1;
      st_next.phase    = (phase_mode_in == DCM_PS_NONE) ? 10'sh000 : cfg_phase;
      st_next.tap      = (phase_mode_in == DCM_PS_VARIABLE)
                         ? TAP_W'(TAPS / 2) : '0;
    end

    // De-skew loop moves the tap until feedback meets the target offset
    if (feedback_used_in && pin_rise[DCM_PIN_FB] && st_reg.period_ok)
    begin
      if (err > EW'(1) && st_reg.tap != '0)
        st_next.tap = st_reg.tap - {{(TAP_W-1){1'b0}}, 1'b1};
      else if (err < -EW'(1) && st_reg.tap != TAP_W'(TAPS - 1))
        st_next.tap = st_reg.tap + {{(TAP_W-1){1'b0}}, 1'b1};
    end

    // Lock counting over aligned feedback or stable reference edges
    if (st_next.ref_stop || (pin_rise[DCM_PIN_REF] && !st_next.period_ok))
      st_next.lock_cnt = '0;
    else if (feedback_used_in ? (pin_rise[DCM_PIN_FB] && aligned && st_reg.period_ok)
                              : pin_rise[DCM_PIN_REF])
    begin
      if (st_reg.lock_cnt != DCM_LOCK_EDGES)
        st_next.lock_cnt = st_reg.lock_cnt + 5'h01;
    end
    st_next.locked = (st_next.lock_cnt == DCM_LOCK_EDGES);

    // Phase step handshake on the synchronised shift clock
    case (st_reg.sh_state)
      DCM_SH_IDLE:
      begin
        if (pin_rise[DCM_PIN_PSC] && pin_lvl[DCM_PIN_REQ]
            && phase_mode_in == DCM_PS_VARIABLE && st_reg.cfg_seen)
        begin
          if (step_ok)
          begin
            st_next.phase    = step_phase;
            st_next.overflow = 1'b0;
          end
          else
            st_next.overflow = 1'b1;
          st_next.sh_state = DCM_SH_WAIT;
        end
      end
      DCM_SH_WAIT:
      begin
        if (!feedback_used_in || !run || (pin_rise[DCM_PIN_FB] && aligned))
          st_next.sh_state = DCM_SH_PULSE;
      end
      DCM_SH_PULSE:
      begin
        if (pin_rise[DCM_PIN_PSC])
        begin
          st_next.shift_done = 1'b1;
          st_next.sh_state   = DCM_SH_END;
        end
      end
      DCM_SH_END:
      begin
        if (pin_rise[DCM_PIN_PSC])
        begin
          st_next.shift_done = 1'b0;
          st_next.sh_state   = DCM_SH_IDLE;
        end
      end
      default:
      begin
        st_next.shift_done = 1'b0;
        st_next.sh_state   = DCM_SH_IDLE;
      end
    endcase

    // Coarse phases from the delayed reference counter
    st_next.clk[DCM_O_P0]   = run & (st_next.gen_cnt < half);
    st_next.clk[DCM_O_P90]  = run & ~high_freq_mode_in
                              & (st_next.gen_cnt >= quarter)
                              & (st_next.gen_cnt < quarter + half);
    st_next.clk[DCM_O_P180] = run & (st_next.gen_cnt >= half);
    st_next.clk[DCM_O_P270] = run & ~high_freq_mode_in
                              & ((st_next.gen_cnt < quarter)
                              | (st_next.gen_cnt >= half + quarter));
    st_next.clk[DCM_O_2X]   = run & ~high_freq_mode_in
                              & ((st_next.gen_cnt < quarter)
                              | ((st_next.gen_cnt >= half)
                              & (st_next.gen_cnt < half + quarter)));
    st_next.clk[DCM_O_2X180] = run & ~high_freq_mode_in
                               & ~st_next.clk[DCM_O_2X];

    // Divider counts cycles of the configured length
    if (!run || st_reg.dv_cnt >= dv_len - {{(PW+4){1'b0}}, 1'b1})
      st_next.dv_cnt = '0;
    else
      st_next.dv_cnt = st_reg.dv_cnt + {{(PW+4){1'b0}}, 1'b1};
    st_next.clk[DCM_O_DV] = run & (st_next.dv_cnt < dv_hi);

    // Synth accumulator toggles 2M times per D reference periods
    if (!run)
    begin
      st_next.fx_acc        = '0;
      st_next.clk[DCM_O_FX] = 1'b0;
    end
    else if (fx_sum >= {1'b0, fx_span})
    begin
      st_next.fx_acc        = fx_sum - {1'b0, fx_span};
      st_next.clk[DCM_O_FX] = ~st_reg.clk[DCM_O_FX];
    end
    else
      st_next.fx_acc = fx_sum;
    st_next.clk[DCM_O_FX180] = run & ~st_next.clk[DCM_O_FX];

    // Synth stopped when it has not toggled for the idle limit
    if (st_next.clk[DCM_O_FX] != st_reg.clk[DCM_O_FX])
      st_next.fx_idle = '0;
    else if (st_reg.fx_idle != DCM_STOP_CYCLES)
      st_next.fx_idle = st_reg.fx_idle + 12'h001;
    st_next.fx_stop = (st_next.fx_idle == DCM_STOP_CYCLES);

    // First four enabled outputs go to the global buffers
    st_next.glb      = '0;
    st_next.glb_over = 1'b0;
    for (int k = 0; k < DCM_NUM_OUT; k++)
    begin
      if (global_enable_in[k])
      begin
        if (used < DCM_NUM_GLB)
          st_next.glb[used[1:0]] = st_next.clk[k];
        else
          st_next.glb_over = 1'b1;
        used = used + 1;
      end
    end
  end

  // Whole manager returns to its initial condition on reset
  always_ff @(posedge clock_in or posedge rst_in)
  begin
    if (rst_in)
      st_reg <= '0;
    else
      st_reg <= st_next;
  end

  // ****************************************************************
  // Outputs
  // ****************************************************************
  assign out_phase_0_out            = st_reg.clk[DCM_O_P0];
  assign out_phase_90_out           = st_reg.clk[DCM_O_P90];
  assign out_phase_180_out          = st_reg.clk[DCM_O_P180];
  assign out_phase_270_out          = st_reg.clk[DCM_O_P270];
  assign doubled_clock_out          = st_reg.clk[DCM_O_2X];
  assign doubled_clock_inverted_out = st_reg.clk[DCM_O_2X180];
  assign divided_clock_out          = st_reg.clk[DCM_O_DV];
  assign synth_clock_out            = st_reg.clk[DCM_O_FX];
  assign synth_clock_inverted_out   = st_reg.clk[DCM_O_FX180];
  assign global_clock_out           = st_reg.glb;
  assign global_overuse_out         = st_reg.glb_over;
  assign lock_flag_out              = st_reg.locked;
  assign shift_complete_out         = st_reg.shift_done;
  assign config_done_out            = ~lock_wait_in | st_reg.locked;

  // Status vector, upper bits unused
  always_comb
  begin
    status_out                  = 8'h00;
    status_out[DCM_ST_OVERFLOW] = st_reg.overflow;
    status_out[DCM_ST_REF_STOP] = st_reg.ref_stop;
    status_out[DCM_ST_FX_STOP]  = st_reg.fx_stop;
  end

endmodule // dcm_clock_manager

// ===== dcm_clock_manager_properties.sv
// ****************************************************************
// Port checks
// ****************************************************************
module dcm_checker
  import dcm_pkg::*;
(
  input  wire logic       clock_in,
  input  wire logic       rst_in,
  input  wire logic       high_freq_mode_in,
  input  wire logic       lock_wait_in,
  input  wire logic [8:0] global_enable_in,
  input  wire logic       out_phase_90_out,
  input  wire logic       doubled_clock_out,
  input  wire logic [3:0] global_clock_out,
  input  wire logic       global_overuse_out,
  input  wire logic       lock_flag_out,
  input  wire logic [7:0] status_out,
  input  wire logic       shift_complete_out,
  input  wire logic       config_done_out
);
  default clocking cb @(posedge clock_in); endclocking
  default disable iff (rst_in);

  reset_clear_a: assert property ($past(rst_in) |-> status_out == 8'h00 && !lock_flag_out)
    else $error("outputs not cleared by reset");
  status_spare_a: assert property (status_out[7:3] == 5'h00)
    else $error("spare status bits set");
  stop_unlock_a: assert property (status_out[1] && $past(status_out[1]) |-> !lock_flag_out)
    else $error("locked while reference stopped");
  config_wait_a: assert property (config_done_out == (!lock_wait_in || lock_flag_out))
    else $error("configuration done before lock");
  hf_outputs_a: assert property (high_freq_mode_in && $past(high_freq_mode_in)
    |-> !out_phase_90_out && !doubled_clock_out) else $error("output alive in high mode");
  overuse_flag_a: assert property (!$past(rst_in) |->
    global_overuse_out == ($countones($past(global_enable_in)) > 4)) else $error("overuse");
  global_idle_a: assert property (!$past(rst_in) && $past(global_enable_in) == 9'h000
    |-> global_clock_out == 4'h0) else $error("global clock without enable");
  done_pulse_a: assert property ($rose(shift_complete_out)
    |-> shift_complete_out [*4] ##[1:40] !shift_complete_out) else $error("done width");
endmodule // dcm_checker

bind dcm_clock_manager dcm_checker i_check (.*);

// ===== dcm_fabric_model.sv
// ****************************************************************
// User fabric: reference, feedback and step handshake
// ****************************************************************
module dcm_fabric_model (
  input  wire logic run_ref_in,
  input  wire logic step_in,
  input  wire logic dir_in,
  input  wire logic phase_0_in,
  input  wire logic shift_done_in,
  output logic      ref_clock_out,
  output logic      feedback_clock_out,
  output logic      shift_clock_out,
  output logic      shift_request_out,
  output logic      shift_direction_out
);
  timeunit 1ns;
  timeprecision 1ns;

  // Reference halts low when not running
  initial ref_clock_out = 1'b0;
  always #500 ref_clock_out = run_ref_in & ~ref_clock_out;
  // Feedback taken from phase zero only
  assign feedback_clock_out = phase_0_in;
  // Free running step clock
  initial shift_clock_out = 1'b0;
  always #100 shift_clock_out = ~shift_clock_out;
  // One request per completion, moved just after a step clock rise
  initial
  begin
    shift_request_out = 1'b0;
    shift_direction_out = 1'b0;
    forever
    begin
      @(posedge shift_clock_out iff step_in);
      #1 shift_direction_out = dir_in;
      shift_request_out = 1'b1;
      @(posedge shift_clock_out);
      #1 shift_request_out = 1'b0;
      @(negedge shift_done_in);
    end
  end
endmodule // dcm_fabric_model

// ===== test_digital_clock_manager.sv
// ****************************************************************
// Bench
// ****************************************************************
module test_digital_clock_manager
  import dcm_pkg::*;
;
  timeunit 1ns;
  timeprecision 100ps;
  logic       clock_in = 1'b0;
  logic       rst_in = 1'b1;
  logic       high_freq_mode_in = 1'b0;
  logic       lock_wait_in = 1'b1;
  logic [8:0] global_enable_in = 9'h000;
  logic [5:0] divide_x2_in = 6'h04;
  logic [4:0] synth_mult_in = 5'h00;
  logic [4:0] synth_div_in = 5'h00;
  logic       run_ref = 1'b0;
  logic       step = 1'b0;
  logic       dir = 1'b0;
  int         bad_count = 0;
  int         checked = 0;
  logic [15:0] hi;
  logic [15:0] per;
  wire logic  ref_clock_in, feedback_clock_in, shift_clock_in, shift_request_in;
  wire logic  shift_direction_in, out_phase_0_out, out_phase_90_out, out_phase_270_out;
  wire logic  doubled_clock_out, doubled_clock_inverted_out, global_overuse_out;
  wire logic  lock_flag_out, shift_complete_out, config_done_out;
  wire logic  out_phase_180_out, divided_clock_out;
  wire logic [3:0] global_clock_out;
  wire logic [7:0] status_out;

  always #12.5 clock_in = ~clock_in;

  dcm_clock_manager i_dut (.*, .feedback_used_in(1'b1), .phase_mode_in(2'h2),
    .phase_offset_setting_in(9'h000), .synth_clock_out(), .synth_clock_inverted_out());
  dcm_fabric_model i_fabric (.run_ref_in(run_ref), .step_in(step), .dir_in(dir),
    .phase_0_in(out_phase_0_out), .shift_done_in(shift_complete_out),
    .ref_clock_out(ref_clock_in), .feedback_clock_out(feedback_clock_in),
    .shift_clock_out(shift_clock_in), .shift_request_out(shift_request_in),
    .shift_direction_out(shift_direction_in));

  // Model: more enables than global buffers
  function automatic logic [8:0] over(input logic [8:0] en);
    int q[$];
    for (int i = 0; i < 9; i++)
      if (en[i])
        q.push_back(i);
    return {8'h00, q.size() > DCM_NUM_GLB};
  endfunction
  // Compare and count
  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    checked++;
    if (seen !== exp)
    begin
      bad_count++;
      $display("ERROR %0t seen %0h expected %0h", $time, seen, exp);
    end
  endtask
  // Verdict and end of run
  task automatic print_verdict();
    if (bad_count == 0 && checked > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask
  // Bounded high time and period of one output, rise to rise
  task automatic measure(input logic sel, output logic [15:0] hi, output logic [15:0] per);
    int   rises;
    logic v;
    logic p;
    rises = 0;
    hi = 16'h0000;
    per = 16'h0000;
    p = 1'b1;
    for (int n = 0; n < 2000 && rises < 2; n++)
    begin
      @(negedge clock_in);
      v = sel ? out_phase_180_out : divided_clock_out;
      rises += int'(v & ~p);
      p = v;
      per += 16'(rises == 1);
      hi += 16'(rises == 1 && v);
    end
    if (rises < 2)
    begin
      bad_count++;
      print_verdict();
    end
  endtask
  // Bounded wait on lock, reference stop or step done
  task automatic wait_for(input int w, input int lim);
    int n;
    n = 0;
    while ((w == 0 ? lock_flag_out : w == 1 ? status_out[1] : shift_complete_out) !== 1'b1)
    begin
      @(negedge clock_in);
      n++;
      if (n > lim)
      begin
        bad_count++;
        print_verdict();
      end
    end
  endtask

  // Main sequence
  initial
  begin
    void'($urandom(56971));
    synth_mult_in = 5'($urandom_range(2, 31));
    synth_div_in = 5'($urandom_range(1, 31));
    divide_x2_in = 6'($urandom_range(3, 24));
    if (divide_x2_in > 6'h10)
      divide_x2_in = (divide_x2_in - 6'h08) << 1;
    repeat (4) @(negedge clock_in);
    rst_in = 1'b0;
    @(negedge clock_in);
    check(lock_flag_out, 0);
    check(status_out, 0);
    check(config_done_out, 0);
    for (int i = 0; i < 6; i++)
    begin
      global_enable_in = (i == 0) ? 9'h1FF : 9'($urandom);
      repeat (2) @(negedge clock_in);
      check(global_overuse_out, over(global_enable_in));
    end
    global_enable_in = 9'h000;
    repeat (2) @(negedge clock_in);
    check(global_clock_out, 0);
    run_ref = 1'b1;
    wait_for(0, 6000);
    check(config_done_out, 1);
    measure(1'b0, hi, per);
    check(per, 16'h0014 * divide_x2_in);
    check(hi, 16'h000A * divide_x2_in);
    measure(1'b1, hi, per);
    check(per, 16'h0028);
    check(hi, 16'h0014);
    dir = 1'($urandom);
    step = 1'b1;
    wait_for(2, 2000);
    step = 1'b0;
    check(status_out, 0);
    repeat (12) @(negedge clock_in);
    check(shift_complete_out, 0);
    high_freq_mode_in = 1'b1;
    repeat (3) @(negedge clock_in);
    repeat (40)
    begin
      @(negedge clock_in);
      check({out_phase_90_out, out_phase_270_out, doubled_clock_out,
        doubled_clock_inverted_out}, 0);
    end
    high_freq_mode_in = 1'b0;
    run_ref = 1'b0;
    wait_for(1, 4200);
    check(lock_flag_out, 0);
    rst_in = 1'b1;
    @(negedge clock_in);
    rst_in = 1'b0;
    @(negedge clock_in);
    check(status_out, 0);
    print_verdict();
  end
endmodule // test_digital_clock_manager
